// >>> core/otg_role_pkg.sv
package otg_role_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] ADDR_LINE_STATUS  = 4'h0;
   localparam logic [3:0] ADDR_PULL_VBUS    = 4'h1;
   localparam logic [3:0] ADDR_POWER_CTRL   = 4'h2;
   localparam logic [3:0] ADDR_DESC_PAGE    = 4'h3;
   localparam logic [3:0] ADDR_FRAME_LOW    = 4'h4;
   localparam logic [3:0] ADDR_FRAME_HIGH   = 4'h5;
   localparam logic [3:0] ADDR_PWM_VALUE    = 4'h6;
   localparam logic [3:0] ADDR_PWM_CONTROL  = 4'h7;
   localparam logic [3:0] ADDR_MODE_CONTROL = 4'h8;

   // Line status bit positions
   localparam int STAT_ID_BIT      = 7;
   localparam int STAT_LSTABLE_BIT = 5;
   localparam int STAT_SESSVLD_BIT = 3;
   localparam int STAT_SESSEND_BIT = 2;
   localparam int STAT_AVBUS_BIT   = 0;

   // Power control bit positions
   localparam int PWR_PEND_BIT  = 7;
   localparam int PWR_GUARD_BIT = 4;
   localparam int PWR_SUSP_BIT  = 1;
   localparam int PWR_EN_BIT    = 0;

   // Mode control bit positions
   localparam int MODE_DEV_EN_BIT  = 0;
   localparam int MODE_RESUME_BIT  = 2;
   localparam int MODE_HOST_EN_BIT = 3;
   localparam int MODE_LOWSPD_BIT  = 7;

   // Reset values and field masks
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0]  PAGE_ALIGN_MASK = 8'hfe;
   localparam logic [10:0] FRAME_MASK_11 = 11'h7ff;

   // Line stability timer: 1 ms at 25 MHz
   localparam int CLK_HZ        = 25000000;
   localparam int LINE_STABLE_US = 1000;
   localparam int LINE_STABLE_CYCLES = (CLK_HZ / 1000) * LINE_STABLE_US / 1000;

   // Control byte of the pull and VBUS register
   typedef struct packed {
      logic dplus_pullup_en;
      logic dminus_pullup_en;
      logic dplus_pulldown_en;
      logic dminus_pulldown_en;
      logic vbus_power_on;
      logic dual_role_pull_sw_ctrl;
      logic vbus_charge_select;
      logic vbus_discharge_en;
   } pull_ctrl_t;

   // Resistor enables driven toward the transceiver
   typedef struct packed {
      logic dplus_pullup;
      logic dminus_pullup;
      logic dplus_pulldown;
      logic dminus_pulldown;
   } pulls_t;

   // Synchronised analog and pin indications
   typedef struct packed {
      logic id_pin;
      logic sess_valid;
      logic sess_end;
      logic a_vbus_valid;
      logic line_se0;
      logic line_j;
   } line_in_t;

   typedef enum logic [2:0] {
      PWR_OFF    = 3'b001,
      PWR_ACTIVE = 3'b010,
      PWR_SUSP   = 3'b100
   } pwr_state_t;

endpackage

// >>> core/usb_otg_role_power_control.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
module usb_otg_role_power_control (
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire logic [3:0]                reg_addr,
   input  wire logic [15:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic [15:0]                    reg_rdata,
   input  wire otg_role_pkg::line_in_t    line_in,
   input  wire logic                      sof_tick,
   input  wire logic                      bus_activity,
   input  wire logic                      resume_detect,
   output otg_role_pkg::pulls_t           pulls,
   output logic                           vbus_power_on,
   output logic                           vbus_charge_select,
   output logic                           vbus_discharge_en,
   output logic                           module_enabled,
   output logic                           usb_clk_gate_n,
   output logic                           xcvr_low_power,
   output logic                           resume_signal,
   output logic                           low_speed_mode
);

   // Three-stage input capture; second and third stages must agree
   otg_role_pkg::line_in_t sync1_reg;
   otg_role_pkg::line_in_t sync2_reg;
   otg_role_pkg::line_in_t sync3_reg;
   otg_role_pkg::line_in_t line_reg;
   otg_role_pkg::line_in_t line_next;
   logic                   act_s1_reg;
   logic                   act_s2_reg;
   logic                   act_s3_reg;
   logic                   res_s1_reg;
   logic                   res_s2_reg;
   logic                   res_s3_reg;

   // Software-visible state
   otg_role_pkg::pull_ctrl_t pull_ctrl_reg;
   logic [7:0]               mode_ctrl_reg;
   logic                     guard_reg;
   logic                     pending_reg;
   logic [7:0]               desc_page_reg;
   logic [10:0]              frame_reg;
   logic [15:0]              pwm_value_reg;
   logic [15:0]              pwm_control_reg;
   otg_role_pkg::pwr_state_t pwr_state_reg;
   otg_role_pkg::pwr_state_t pwr_state_next;

   // Line stability timer
   logic [1:0]  line_last_reg;
   logic [15:0] stable_cnt_reg;
   logic        stable_reg;

   // Next values for the output registers
   otg_role_pkg::pulls_t pulls_next;
   logic [15:0]          rdata_next;

   // Decoded strobes
   wire logic wr_line_pull  = reg_wr && (reg_addr == otg_role_pkg::ADDR_PULL_VBUS);
   wire logic wr_power      = reg_wr && (reg_addr == otg_role_pkg::ADDR_POWER_CTRL);
   wire logic wr_desc_page  = reg_wr && (reg_addr == otg_role_pkg::ADDR_DESC_PAGE);
   wire logic wr_frame_low  = reg_wr && (reg_addr == otg_role_pkg::ADDR_FRAME_LOW);
   wire logic wr_frame_high = reg_wr && (reg_addr == otg_role_pkg::ADDR_FRAME_HIGH);
   wire logic wr_pwm_value  = reg_wr && (reg_addr == otg_role_pkg::ADDR_PWM_VALUE);
   wire logic wr_pwm_ctrl   = reg_wr && (reg_addr == otg_role_pkg::ADDR_PWM_CONTROL);
   wire logic wr_mode       = reg_wr && (reg_addr == otg_role_pkg::ADDR_MODE_CONTROL);

   // Filtered inputs update only when stages two and three agree
   always_comb begin
      line_next = line_reg;
      if (sync2_reg.id_pin == sync3_reg.id_pin) line_next.id_pin = sync3_reg.id_pin;
      if (sync2_reg.sess_valid == sync3_reg.sess_valid) line_next.sess_valid = sync3_reg.sess_valid;
      if (sync2_reg.sess_end == sync3_reg.sess_end) line_next.sess_end = sync3_reg.sess_end;
      if (sync2_reg.a_vbus_valid == sync3_reg.a_vbus_valid) begin
         line_next.a_vbus_valid = sync3_reg.a_vbus_valid;
      end
      if (sync2_reg.line_se0 == sync3_reg.line_se0) line_next.line_se0 = sync3_reg.line_se0;
      if (sync2_reg.line_j == sync3_reg.line_j) line_next.line_j = sync3_reg.line_j;
   end

   // Synchroniser chains
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sync1_reg  <= '0;
         sync2_reg  <= '0;
         sync3_reg  <= '0;
         line_reg   <= '0;
         act_s1_reg <= 1'b0;
         act_s2_reg <= 1'b0;
         act_s3_reg <= 1'b0;
         res_s1_reg <= 1'b0;
         res_s2_reg <= 1'b0;
         res_s3_reg <= 1'b0;
      end else begin
         sync1_reg  <= line_in;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         line_reg   <= line_next;
         act_s1_reg <= bus_activity;
         act_s2_reg <= act_s1_reg;
         act_s3_reg <= act_s2_reg;
         res_s1_reg <= resume_detect;
         res_s2_reg <= res_s1_reg;
         res_s3_reg <= res_s2_reg;
      end
   end

   // Line state (SE0, J) stability over the last millisecond
   wire logic [1:0] line_now     = {line_reg.line_se0, line_reg.line_j};
   wire logic       line_changed = (line_now != line_last_reg);
   wire logic       stable_hit   =
      (stable_cnt_reg == 16'(otg_role_pkg::LINE_STABLE_CYCLES - 1));

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         line_last_reg  <= 2'h0;
         stable_cnt_reg <= 16'h0000;
         stable_reg     <= 1'b0;
      end else begin
         line_last_reg <= line_now;
         if (line_changed) begin
            stable_cnt_reg <= 16'h0000;
            stable_reg     <= 1'b0;
         end else if (stable_hit) begin
            stable_reg     <= 1'b1;
         end else begin
            stable_cnt_reg <= stable_cnt_reg + 16'h0001;
         end
      end
   end

   // Status byte assembled from synchronised indications
   wire logic [7:0] status_byte = {
      line_reg.id_pin,
      1'b0,
      stable_reg,
      1'b0,
      line_reg.sess_valid,
      line_reg.sess_end,
      1'b0,
      line_reg.a_vbus_valid
   };

   // Suspend and enable sequencing
   wire logic sw_enable   = wr_power && reg_wdata[otg_role_pkg::PWR_EN_BIT];
   wire logic sw_suspend  = wr_power && reg_wdata[otg_role_pkg::PWR_SUSP_BIT];
   wire logic wake_event  = res_s2_reg && res_s3_reg;
   wire logic activity_ok = act_s2_reg && act_s3_reg;

   always_comb begin
      pwr_state_next = pwr_state_reg;
      case (pwr_state_reg)
         otg_role_pkg::PWR_OFF: begin
            // Enable and suspend in one write goes straight to suspend
            if (sw_enable && sw_suspend) pwr_state_next = otg_role_pkg::PWR_SUSP;
            else if (sw_enable) pwr_state_next = otg_role_pkg::PWR_ACTIVE;
         end
         otg_role_pkg::PWR_ACTIVE: begin
            if (wr_power && !sw_enable) pwr_state_next = otg_role_pkg::PWR_OFF;
            else if (sw_suspend) pwr_state_next = otg_role_pkg::PWR_SUSP;
         end
         otg_role_pkg::PWR_SUSP: begin
            if (wr_power && !sw_enable) pwr_state_next = otg_role_pkg::PWR_OFF;
            else if (wake_event) pwr_state_next = otg_role_pkg::PWR_ACTIVE;
            else if (wr_power && !sw_suspend) pwr_state_next = otg_role_pkg::PWR_ACTIVE;
         end
         default: pwr_state_next = otg_role_pkg::PWR_OFF;
      endcase
   end

   // Control and data registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pull_ctrl_reg   <= '0;
         mode_ctrl_reg   <= otg_role_pkg::RST_BYTE;
         guard_reg       <= 1'b0;
         pending_reg     <= 1'b0;
         desc_page_reg   <= otg_role_pkg::RST_BYTE;
         pwm_value_reg   <= otg_role_pkg::RST_WORD;
         pwm_control_reg <= otg_role_pkg::RST_WORD;
         pwr_state_reg   <= otg_role_pkg::PWR_OFF;
      end else begin
         pwr_state_reg <= pwr_state_next;
         if (wr_line_pull) pull_ctrl_reg <= reg_wdata[7:0];
         if (wr_mode) mode_ctrl_reg <= reg_wdata[7:0];
         if (wr_power) guard_reg <= reg_wdata[otg_role_pkg::PWR_GUARD_BIT];
         if (wr_desc_page) desc_page_reg <= reg_wdata[7:0] & otg_role_pkg::PAGE_ALIGN_MASK;
         if (wr_pwm_value) pwm_value_reg <= reg_wdata;
         if (wr_pwm_ctrl) pwm_control_reg <= reg_wdata;
         // Set by activity wins over a software clear; meaningful only with guard
         if (activity_ok && (guard_reg || (wr_power && reg_wdata[otg_role_pkg::PWR_GUARD_BIT]))) begin
            pending_reg <= 1'b1;
         end else if (wr_power || !guard_reg) begin
            pending_reg <= 1'b0;
         end
      end
   end

   // Frame counter: advances on each start-of-frame tick
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         frame_reg <= 11'h000;
      end else if (sof_tick) begin
         frame_reg <= (frame_reg + 11'h001) & otg_role_pkg::FRAME_MASK_11;
      end else if (wr_frame_low) begin
         frame_reg <= {frame_reg[10:8], reg_wdata[7:0]};
      end else if (wr_frame_high) begin
         frame_reg <= {reg_wdata[2:0], frame_reg[7:0]};
      end
   end

   // Resistor selection: manual bits or hardware default from mode bits
   wire logic host_en = mode_ctrl_reg[otg_role_pkg::MODE_HOST_EN_BIT];
   wire logic dev_en  = mode_ctrl_reg[otg_role_pkg::MODE_DEV_EN_BIT];
   wire logic powered = (pwr_state_reg != otg_role_pkg::PWR_OFF);

   always_comb begin
      if (pull_ctrl_reg.dual_role_pull_sw_ctrl) begin
         pulls_next.dplus_pullup    = pull_ctrl_reg.dplus_pullup_en;
         pulls_next.dminus_pullup   = pull_ctrl_reg.dminus_pullup_en;
         pulls_next.dplus_pulldown  = pull_ctrl_reg.dplus_pulldown_en;
         pulls_next.dminus_pulldown = pull_ctrl_reg.dminus_pulldown_en;
      end else begin
         pulls_next.dplus_pullup    = dev_en && !host_en;
         pulls_next.dminus_pullup   = 1'b0;
         pulls_next.dplus_pulldown  = host_en;
         pulls_next.dminus_pulldown = host_en;
      end
      if (!powered) pulls_next = '0;
   end

   // Read data, upper byte zero except for the PWM pair
   wire logic [7:0] power_byte = {pending_reg && guard_reg, 2'b00, guard_reg, 2'b00,
                                  pwr_state_reg == otg_role_pkg::PWR_SUSP, powered};

   always_comb begin
      if (reg_addr == otg_role_pkg::ADDR_LINE_STATUS) rdata_next = {8'h00, status_byte};
      else if (reg_addr == otg_role_pkg::ADDR_PULL_VBUS) rdata_next = {8'h00, pull_ctrl_reg};
      else if (reg_addr == otg_role_pkg::ADDR_POWER_CTRL) rdata_next = {8'h00, power_byte};
      else if (reg_addr == otg_role_pkg::ADDR_DESC_PAGE) rdata_next = {8'h00, desc_page_reg};
      else if (reg_addr == otg_role_pkg::ADDR_FRAME_LOW) rdata_next = {8'h00, frame_reg[7:0]};
      else if (reg_addr == otg_role_pkg::ADDR_FRAME_HIGH) rdata_next = {13'h0000, frame_reg[10:8]};
      else if (reg_addr == otg_role_pkg::ADDR_PWM_VALUE) rdata_next = pwm_value_reg;
      else if (reg_addr == otg_role_pkg::ADDR_PWM_CONTROL) rdata_next = pwm_control_reg;
      else if (reg_addr == otg_role_pkg::ADDR_MODE_CONTROL) rdata_next = {8'h00, mode_ctrl_reg};
      else rdata_next = 16'h0000;
   end

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata          <= 16'h0000;
         pulls              <= '0;
         vbus_power_on      <= 1'b0;
         vbus_charge_select <= 1'b0;
         vbus_discharge_en  <= 1'b0;
         module_enabled     <= 1'b0;
         usb_clk_gate_n     <= 1'b0;
         xcvr_low_power     <= 1'b1;
         resume_signal      <= 1'b0;
         low_speed_mode     <= 1'b0;
      end else begin
         reg_rdata          <= reg_rd ? rdata_next : 16'h0000;
         pulls              <= pulls_next;
         vbus_power_on      <= pull_ctrl_reg.vbus_power_on;
         vbus_charge_select <= pull_ctrl_reg.vbus_charge_select;
         vbus_discharge_en  <= pull_ctrl_reg.vbus_discharge_en;
         module_enabled     <= powered;
         usb_clk_gate_n     <= (pwr_state_reg == otg_role_pkg::PWR_ACTIVE);
         xcvr_low_power     <= (pwr_state_reg != otg_role_pkg::PWR_ACTIVE);
         resume_signal      <= mode_ctrl_reg[otg_role_pkg::MODE_RESUME_BIT];
         low_speed_mode     <= mode_ctrl_reg[otg_role_pkg::MODE_LOWSPD_BIT];
      end
   end

endmodule // usb_otg_role_power_control

// >>> dv/usb_otg_role_power_control_chk.sv
`timescale 1ns/10ps
module usb_otg_role_power_control_chk (
   input wire logic                 ref_clk,
   input wire logic                 reset_n,
   input wire logic [3:0]           reg_addr,
   input wire logic [15:0]          reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [15:0]          reg_rdata,
   input wire otg_role_pkg::pulls_t pulls,
   input wire logic                 vbus_power_on,
   input wire logic                 vbus_charge_select,
   input wire logic                 vbus_discharge_en,
   input wire logic                 module_enabled,
   input wire logic                 usb_clk_gate_n,
   input wire logic                 xcvr_low_power,
   input wire logic                 resume_signal
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Write decodes and the fields they carry
   wire       pull_wr   = reg_wr && reg_addr == otg_role_pkg::ADDR_PULL_VBUS;
   wire       pwr_wr    = reg_wr && reg_addr == otg_role_pkg::ADDR_POWER_CTRL;
   wire       mode_wr   = reg_wr && reg_addr == otg_role_pkg::ADDR_MODE_CONTROL;
   wire [3:0] pull_bits = reg_wdata[7:4];
   wire [2:0] vbus_bits = {reg_wdata[3], reg_wdata[1], reg_wdata[0]};
   wire       res_bit   = reg_wdata[otg_role_pkg::MODE_RESUME_BIT];
   wire [3:0] last_addr = reg_addr;

   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
   upper_byte_a: assert property ($past(reg_rd)
      && $past(last_addr) != otg_role_pkg::ADDR_PWM_VALUE
      && $past(last_addr) != otg_role_pkg::ADDR_PWM_CONTROL |-> reg_rdata[15:8] == 8'h00)
      else $error("upper byte of a byte register not zero");
   page_align_a: assert property ($past(reg_rd)
      && $past(last_addr) == otg_role_pkg::ADDR_DESC_PAGE |-> !reg_rdata[0])
      else $error("descriptor page bit 0 set");
   frame_high_a: assert property ($past(reg_rd)
      && $past(last_addr) == otg_role_pkg::ADDR_FRAME_HIGH |-> reg_rdata[7:3] == 5'h00)
      else $error("frame high beyond 11 bits");
   status_gap_a: assert property ($past(reg_rd)
      && $past(last_addr) == otg_role_pkg::ADDR_LINE_STATUS
      |-> {reg_rdata[6], reg_rdata[4], reg_rdata[1]} == 3'b000)
      else $error("unused status bit set");
   manual_pulls_a: assert property (pull_wr && reg_wdata[2]
      ##1 !pull_wr && !pwr_wr && module_enabled
      ##1 module_enabled |-> pulls == $past(pull_bits, 2))
      else $error("manual pulls not applied");
   vbus_copy_a: assert property (pull_wr ##1 !pull_wr && module_enabled
      |-> ##1 {vbus_power_on, vbus_charge_select, vbus_discharge_en} == $past(vbus_bits, 2))
      else $error("vbus controls do not follow register");
   clock_gate_a: assert property (usb_clk_gate_n |-> module_enabled && !xcvr_low_power)
      else $error("clock runs while off or suspended");
   off_state_a: assert property (!module_enabled && $past(!module_enabled)
      |-> xcvr_low_power && pulls == 4'h0)
      else $error("pulls or transceiver active while off");
   suspend_a: assert property (pwr_wr && reg_wdata[1:0] == 2'b11
      |-> ##2 !usb_clk_gate_n && xcvr_low_power)
      else $error("suspend not entered");
   resume_out_a: assert property (mode_wr ##1 !mode_wr |-> ##1 resume_signal == $past(res_bit, 2))
      else $error("resume output does not follow register");

   // Main scenarios reached
   cover property (pull_wr && reg_wdata[2]);
   cover property (pwr_wr && reg_wdata[1]);
   cover property ($past(reg_rd) && $past(last_addr) == otg_role_pkg::ADDR_POWER_CTRL && reg_rdata[7]);
endmodule // usb_otg_role_power_control_chk

bind usb_otg_role_power_control usb_otg_role_power_control_chk i_chk (.ref_clk, .reset_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pulls, .vbus_power_on,
   .vbus_charge_select, .vbus_discharge_en, .module_enabled, .usb_clk_gate_n,
   .xcvr_low_power, .resume_signal);

// >>> dv/otg_far_device.sv
`timescale 1ns/10ps
module otg_far_device (
   input  wire otg_role_pkg::pulls_t pulls,
   input  wire logic                 vbus_power_on,
   input  wire logic                 far_dplus_pullup,
   input  wire logic                 plug_is_a,
   output otg_role_pkg::line_in_t    line_in
);
   // A D+ pull-up on either end gives J; no pull-up leaves SE0
   assign line_in.line_j       = pulls.dplus_pullup | far_dplus_pullup;
   assign line_in.line_se0     = ~line_in.line_j & ~pulls.dminus_pullup;
   // VBUS follows this end's vbus_power_on, whichever end is A
   assign line_in.sess_valid   = vbus_power_on;
   assign line_in.sess_end     = ~vbus_power_on;
   assign line_in.a_vbus_valid = vbus_power_on;
   assign line_in.id_pin       = ~plug_is_a;
endmodule // otg_far_device

// >>> dv/usb_otg_role_power_control_tb_top.sv
`timescale 1ns/10ps
module usb_otg_role_power_control_tb_top;
   logic                   ref_clk = 1'b0;
   logic                   reset_n = 1'b0;
   logic [3:0]             reg_addr = 4'h0;
   logic [15:0]            reg_wdata = 16'h0000;
   logic                   reg_wr = 1'b0;
   logic                   reg_rd = 1'b0;
   logic                   sof_tick = 1'b0;
   logic                   bus_activity = 1'b0;
   logic                   resume_detect = 1'b0;
   logic                   far_dplus_pullup = 1'b1;
   logic                   plug_is_a = 1'b0;
   logic [15:0]            reg_rdata;
   logic [15:0]            rd_val;
   otg_role_pkg::line_in_t line_in;
   otg_role_pkg::pulls_t   pulls;
   logic                   vbus_power_on, vbus_charge_select, vbus_discharge_en;
   logic                   module_enabled, usb_clk_gate_n, xcvr_low_power;
   logic                   resume_signal, low_speed_mode;
   int                     err_count = 0;
   int                     cmp_count = 0;

   usb_otg_role_power_control i_dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .line_in, .sof_tick, .bus_activity, .resume_detect, .pulls,
      .vbus_power_on, .vbus_charge_select, .vbus_discharge_en, .module_enabled,
      .usb_clk_gate_n, .xcvr_low_power, .resume_signal, .low_speed_mode);
   otg_far_device i_far (.pulls, .vbus_power_on, .far_dplus_pullup, .plug_is_a, .line_in);

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   function automatic logic [15:0] outs();
      return {4'h0, pulls, vbus_power_on, vbus_charge_select, vbus_discharge_en,
              module_enabled, usb_clk_gate_n, xcvr_low_power, resume_signal, low_speed_mode};
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus cycles: one-cycle strobes, read data taken in the following cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic t_reset_values();
      for (int a = 0; a < 16; a++) begin
         rdchk(4'(a), (a == 0) ? 16'h0084 : 16'h0000);
      end
      chk(outs(), 16'h0004);
   endtask
   task automatic t_data_regs();
      wr(otg_role_pkg::ADDR_DESC_PAGE, 16'hffff);
      rdchk(otg_role_pkg::ADDR_DESC_PAGE, {8'h00, otg_role_pkg::PAGE_ALIGN_MASK});
      wr(otg_role_pkg::ADDR_PWM_VALUE, 16'ha55a);
      rdchk(otg_role_pkg::ADDR_PWM_VALUE, 16'ha55a);
      wr(otg_role_pkg::ADDR_FRAME_LOW, 16'hffff);
      wr(otg_role_pkg::ADDR_FRAME_HIGH, 16'hffff);
      rdchk(otg_role_pkg::ADDR_FRAME_LOW, 16'h00ff);
      rdchk(otg_role_pkg::ADDR_FRAME_HIGH, 16'h0007);
      @(posedge ref_clk);
      sof_tick <= 1'b1;
      @(posedge ref_clk);
      sof_tick <= 1'b0;
      rdchk(otg_role_pkg::ADDR_FRAME_LOW, 16'h0000);
      rdchk(otg_role_pkg::ADDR_FRAME_HIGH, 16'h0000);
      wr(4'hf, 16'hffff);
      rdchk(4'hf, 16'h0000);
   endtask
   task automatic t_pulls_vbus();
      wr(otg_role_pkg::ADDR_POWER_CTRL, 16'h0001);
      wr(otg_role_pkg::ADDR_MODE_CONTROL, 16'h0001);
      settle(2);
      chk(outs(), 16'h0818);
      wr(otg_role_pkg::ADDR_MODE_CONTROL, 16'h0008);
      settle(2);
      chk(outs(), 16'h0318);
      for (int i = 4; i < 8; i++) begin
         wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h0004 | (16'h0001 << i));
         settle(1);
         chk({12'h000, pulls}, 16'h0001 << (i - 4));
      end
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h000b);
      settle(6);
      chk(outs(), 16'h0318 | 16'h00e0);
      rdchk(otg_role_pkg::ADDR_LINE_STATUS, 16'h0089);
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h0008);
      settle(1);
      chk({13'h0000, vbus_power_on, vbus_charge_select, vbus_discharge_en}, 16'h0004);
   endtask
   task automatic t_role_swap();
      @(posedge ref_clk);
      plug_is_a <= 1'b1;
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h003c);
      far_dplus_pullup <= 1'b0;
      settle(6);
      rdchk(otg_role_pkg::ADDR_LINE_STATUS, 16'h0009);
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h00bc);
      settle(6);
      chk({12'h000, pulls}, 16'h000b);
      settle(otg_role_pkg::LINE_STABLE_CYCLES - 20);
      rdchk(otg_role_pkg::ADDR_LINE_STATUS, 16'h0009);
      settle(30);
      rdchk(otg_role_pkg::ADDR_LINE_STATUS, 16'h0029);
      @(posedge ref_clk);
      far_dplus_pullup <= 1'b1;
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h003c);
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h0034);
      settle(6);
      rdchk(otg_role_pkg::ADDR_LINE_STATUS, 16'h0024);
      wr(otg_role_pkg::ADDR_MODE_CONTROL, 16'h000c);
      settle(1);
      chk({15'h0000, resume_signal}, 16'h0001);
      wr(otg_role_pkg::ADDR_MODE_CONTROL, 16'h0088);
      settle(1);
      chk({14'h0000, resume_signal, low_speed_mode}, 16'h0001);
   endtask
   task automatic t_power();
      wr(otg_role_pkg::ADDR_MODE_CONTROL, 16'h0000);
      wr(otg_role_pkg::ADDR_PULL_VBUS, 16'h0000);
      wr(otg_role_pkg::ADDR_POWER_CTRL, 16'h0011);
      bus_activity <= 1'b1;
      settle(6);
      rdchk(otg_role_pkg::ADDR_POWER_CTRL, 16'h0091);
      wr(otg_role_pkg::ADDR_POWER_CTRL, 16'h0001);
      settle(6);
      rdchk(otg_role_pkg::ADDR_POWER_CTRL, 16'h0001);
      @(posedge ref_clk);
      bus_activity <= 1'b0;
      wr(otg_role_pkg::ADDR_POWER_CTRL, 16'h0003);
      settle(2);
      chk({14'h0000, usb_clk_gate_n, xcvr_low_power}, 16'h0001);
      @(posedge ref_clk);
      resume_detect <= 1'b1;
      for (int n = 0; n < 20 && usb_clk_gate_n !== 1'b1; n++) begin
         settle(1);
      end
      @(posedge ref_clk);
      resume_detect <= 1'b0;
      rdchk(otg_role_pkg::ADDR_POWER_CTRL, 16'h0001);
      wr(otg_role_pkg::ADDR_POWER_CTRL, 16'h0000);
      settle(2);
      chk(outs(), 16'h0004);
      wr(otg_role_pkg::ADDR_POWER_CTRL, 16'h0003);
      settle(2);
      chk(outs(), 16'h0014);
   endtask

   // Watchdog sized well past the longest wait
   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      settle(6);
      t_reset_values();
      t_data_regs();
      t_pulls_vbus();
      t_role_swap();
      t_power();
      conclude();
   end
endmodule // usb_otg_role_power_control_tb_top
